// ===== sscr_pkg.sv
// package of offsets, layouts, reset values and carrier types for the sequencer/chopper bank
package sscr_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0]  SSCR_IDX_MSTEP   = 8'h6a;
  localparam logic [7:0]  SSCR_IDX_CHOP    = 8'h6c;
  localparam logic [7:0]  SSCR_IDX_DRVST   = 8'h6f;
  localparam logic [7:0]  SSCR_IDX_QUIET_PWM_CONFIGURATION = 8'h70;
  localparam logic [7:0]  SSCR_IDX_PWMRES  = 8'h71;
  localparam logic [7:0]  SSCR_IDX_PWMAUTO = 8'h72;
  // own additions: interrupt status and mask
  localparam logic [7:0]  SSCR_IDX_IRQST   = 8'h78;
  localparam logic [7:0]  SSCR_IDX_IRQMSK  = 8'h79;
  // reset values
  localparam logic [31:0] SSCR_CHOP_RST    = 32'h13008001;
  localparam logic [31:0] SSCR_QUIET_PWM_CONFIGURATION_RST = 32'hc40d1024;
  // widths and field positions
  localparam int          SSCR_MSTEP_W     = 10;
  localparam int          SSCR_QUIET_PWM_CONFIGURATION_W   = 22;
  localparam logic [9:0]  SSCR_COIL_OFS    = 10'h100;
  localparam int          SSCR_DUTY_LSB    = 0;
  localparam int          SSCR_SOFS_LSB    = 16;
  localparam int          SSCR_AOFS_LSB    = 0;
  localparam int          SSCR_AGRAD_LSB   = 16;
  localparam int          SSCR_NIRQ        = 3;
  // interrupt bits: wrap of counter, status change, regulator update
  localparam int          SSCR_IRQ_WRAP    = 0;
  localparam int          SSCR_IRQ_DRV     = 1;
  localparam int          SSCR_IRQ_REG     = 2;

  // values coming from the motion and regulation cores
  typedef struct packed {
    logic [9:0]  mstep;      // microstep table index
    logic [31:0] driver_status_flags; // driver flags and current level
    logic [7:0]  duty;       // applied duty cycle
    logic [8:0]  sofs;       // signed regulator offset
    logic [7:0]  aofs;       // auto offset
    logic [7:0]  agrad;      // auto gradient
    logic        reg_upd;    // regulator produced a new result
  } sscr_core_type;

  // wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [9:0]  adr;        // byte address bits
    logic [31:0] dat;
  } sscr_wb_req_type;
endpackage

// ===== sscr_coil_index.sv
// coil table index pair from the microstep counter
`timescale 1ns/10ps
`default_nettype none
module sscr_coil_index
  import sscr_pkg::*;
(
  input  wire logic [9:0] mstep_i,       // microstep counter
  output logic      [9:0] first_idx_o,   // first coil table index
  output logic      [9:0] second_idx_o   // second coil table index
);
  // 10-bit add wraps modulo the full wave, so both coils stay in period
  assign first_idx_o  = mstep_i;
  assign second_idx_o = 10'(mstep_i + SSCR_COIL_OFS);
endmodule
`default_nettype wire

// ===== sscr_regs.sv
// wishbone register bank for the sequencer and chopper section
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sscr_regs
  import sscr_pkg::*;
(
  input  wire logic        clk_i,            // 100 MHz clock
  input  wire logic        rst_i,            // synchronous reset, high
  input  wire logic        ce_i,             // clock enable, freezes all state
  input  wire logic        wb_cyc_i,         // wishbone cycle
  input  wire logic        wb_stb_i,         // wishbone strobe
  input  wire logic        wb_we_i,          // write enable
  input  wire logic [3:0]  wb_sel_i,         // byte lanes
  input  wire logic [9:0]  wb_adr_i,         // byte address
  input  wire logic [31:0] wb_dat_i,         // write data
  output logic      [31:0] wb_dat_o,         // read data
  output logic             wb_ack_o,         // acknowledge
  input  wire logic [9:0]  mstep_i,          // microstep position
  input  wire logic [31:0] driver_status_flags_i,     // driver status flags
  input  wire logic [7:0]  duty_i,           // applied duty cycle
  input  wire logic [8:0]  sofs_i,           // regulator signed offset
  input  wire logic [7:0]  aofs_i,           // auto offset value
  input  wire logic [7:0]  agrad_i,          // auto gradient value
  input  wire logic        reg_upd_i,        // regulator update pulse
  output logic      [31:0] chop_cfg_o,       // chopper configuration
  output logic      [21:0] pwm_cfg_o,        // quiet pwm configuration
  output logic      [9:0]  first_idx_o,      // first coil table index
  output logic      [9:0]  second_idx_o,     // second coil table index
  output logic             irq_o             // level interrupt
);

  // behaviour in short:
  // - a taken request is answered by one ack pulse in the next cycle
  // - the ack cycle never takes a request, so a master that keeps its
  //   strobe up across ack is served once, not twice
  // - read data is loaded on every taken request, writes included;
  //   it is only meaningful in the ack cycle of a read
  // - core reports are sampled copies one cycle behind their inputs;
  //   the extra cycle keeps the read path short and the mux registered
  // - events are found on those copies, so while ce is low a change
  //   that comes and goes again is missed; this is accepted
  // - the pwm word keeps its 22 implemented bits, upper write bits are
  //   dropped and read back as zero
  // - write-one-to-clear loses against an event in the same cycle,
  //   so no event is ever lost to a late clear

  // complete module state
  typedef struct packed {
    logic [31:0]            chop;      // chopper configuration
    logic [21:0]            pwm;       // pwm configuration
    logic [31:0]            rdat;      // registered read data
    logic                   ack;       // ack flop
    sscr_core_type          core;      // sampled core values
    logic [SSCR_NIRQ-1:0]   ist;       // sticky status
    logic [SSCR_NIRQ-1:0]   imsk;      // interrupt mask
  } sscr_state_type;

  sscr_state_type st;        // current state
  sscr_state_type next_st;   // next state
  sscr_wb_req_type req;      // bundled request
  sscr_core_type   core_in;  // bundled core inputs

  // apply byte lanes to a 32-bit register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // word index from byte address
  function automatic logic [7:0] word_idx(input logic [9:0] adr);
    return adr[9:2];
  endfunction

  // word indices that answer with a defined register
  function automatic logic is_mapped(input logic [7:0] widx);
    logic hit;
    hit = 1'b0;
    case (widx)
      SSCR_IDX_MSTEP, SSCR_IDX_CHOP, SSCR_IDX_DRVST, SSCR_IDX_QUIET_PWM_CONFIGURATION,
      SSCR_IDX_PWMRES, SSCR_IDX_PWMAUTO, SSCR_IDX_IRQST, SSCR_IDX_IRQMSK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // word indices whose content only mirrors the motion and regulation cores
  function automatic logic is_readonly(input logic [7:0] widx);
    logic ro;
    ro = 1'b0;
    case (widx)
      SSCR_IDX_MSTEP, SSCR_IDX_DRVST, SSCR_IDX_PWMRES, SSCR_IDX_PWMAUTO: ro = 1'b1;
      default: ro = 1'b0;
    endcase
    return ro;
  endfunction

  // bundle ports into carriers
  always_comb begin
    req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
            adr: wb_adr_i, dat: wb_dat_i};
    core_in = '{mstep: mstep_i, driver_status_flags: driver_status_flags_i, duty: duty_i,
                sofs: sofs_i, aofs: aofs_i, agrad: agrad_i, reg_upd: reg_upd_i};
  end

  logic             take;      // a new request accepted this cycle
  logic             wr_take;   // accepted write
  logic [7:0]       idx;       // word index of request
  logic [SSCR_NIRQ-1:0] ev;    // event pulses this cycle
  logic [31:0]      rd_mux;    // read data selection
  logic [31:0]      wmask;     // lane-expanded write data

  // next-state logic
  always_comb begin
    next_st = st;
    idx     = word_idx(req.adr);
    // one-cycle gap after each ack answers the classic handshake
    take    = req.cyc && req.stb && !st.ack;
    wr_take = take && req.we;
    wmask   = lane_merge(32'h0, req.dat, req.sel);

    // core values sampled every cycle; software cannot touch them
    next_st.core = core_in;

    // events: counter wrap, status change, regulator update
    ev = '0;
    ev[SSCR_IRQ_WRAP] = (st.core.mstep == 10'h3ff) && (core_in.mstep == 10'h000);
    ev[SSCR_IRQ_DRV]  = (st.core.driver_status_flags != core_in.driver_status_flags);
    ev[SSCR_IRQ_REG]  = core_in.reg_upd;

    // read multiplexer, unmapped addresses read zero
    case (idx)
      SSCR_IDX_MSTEP:   rd_mux = {22'h0, st.core.mstep};
      SSCR_IDX_CHOP:    rd_mux = st.chop;
      SSCR_IDX_DRVST:   rd_mux = st.core.driver_status_flags;
      SSCR_IDX_QUIET_PWM_CONFIGURATION: rd_mux = {10'h0, st.pwm};
      SSCR_IDX_PWMRES:  rd_mux = {7'h0, st.core.sofs, 8'h0, st.core.duty};
      SSCR_IDX_PWMAUTO: rd_mux = {8'h0, st.core.agrad, 8'h0, st.core.aofs};
      SSCR_IDX_IRQST:   rd_mux = {29'h0, st.ist};
      SSCR_IDX_IRQMSK:  rd_mux = {29'h0, st.imsk};
      default:          rd_mux = 32'h0;
    endcase

    // writes reach only the two configuration words and interrupt control
    next_st.ist = st.ist;
    if (wr_take) begin
      case (idx)
        SSCR_IDX_CHOP:    next_st.chop = lane_merge(st.chop, req.dat, req.sel);
        SSCR_IDX_QUIET_PWM_CONFIGURATION: next_st.pwm  =
          22'(lane_merge({10'h0, st.pwm}, req.dat, req.sel));
        SSCR_IDX_IRQST:   next_st.ist  = st.ist & ~wmask[SSCR_NIRQ-1:0];
        SSCR_IDX_IRQMSK:  next_st.imsk = wmask[SSCR_NIRQ-1:0] |
                                         (st.imsk & ~{SSCR_NIRQ{req.sel[0]}});
        // read-only and unmapped words drop the write, still acked
        default:          next_st.chop = st.chop;
      endcase
    end
    // set wins over a simultaneous clear
    next_st.ist = next_st.ist | ev;

    next_st.ack  = take;
    next_st.rdat = take ? rd_mux : st.rdat;
  end

  // state register with synchronous reset and clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= '0;
      st.chop <= SSCR_CHOP_RST;
      st.pwm  <= SSCR_QUIET_PWM_CONFIGURATION_RST[SSCR_QUIET_PWM_CONFIGURATION_W-1:0];
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // coil index helper
  sscr_coil_index u_coil (
    .mstep_i      (st.core.mstep),
    .first_idx_o  (first_idx_o),
    .second_idx_o (second_idx_o)
  );

  // outputs from flops
  assign wb_dat_o   = st.rdat;
  assign wb_ack_o   = st.ack;
  assign chop_cfg_o = st.chop;
  assign pwm_cfg_o  = st.pwm;
  assign irq_o      = |(st.ist & st.imsk);

  // assertions
  a_ro_mstep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && req.we && idx == SSCR_IDX_MSTEP) |=> (st.core.mstep == $past(mstep_i)))
    else $error("microstep readback altered by write");
  a_chop_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx == SSCR_IDX_CHOP && req.sel == 4'hf) |=> (chop_cfg_o == $past(wb_dat_i)))
    else $error("chopper write not stored");
  a_pwm_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx == SSCR_IDX_QUIET_PWM_CONFIGURATION && req.sel == 4'hf)
      |=> (pwm_cfg_o == $past(wb_dat_i[21:0])))
    else $error("pwm config write not stored");
  a_chop_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx != SSCR_IDX_CHOP) |=> $stable(chop_cfg_o))
    else $error("chopper config changed by foreign write");
  a_duty_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_PWMRES)
      |=> (wb_ack_o && wb_dat_o[7:0] == $past(st.core.duty)))
    else $error("duty readback wrong");
  a_sofs_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_PWMRES)
      |=> (wb_dat_o[24:16] == $past(st.core.sofs) && wb_dat_o[31:25] == 7'h0))
    else $error("offset readback wrong");
  a_auto_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_PWMAUTO)
      |=> (wb_dat_o == {8'h0, $past(st.core.agrad), 8'h0, $past(st.core.aofs)}))
    else $error("auto values readback wrong");
  a_coil_offset: assert property (@(posedge clk_i) disable iff (rst_i)
    (first_idx_o == st.core.mstep) && (second_idx_o == 10'(st.core.mstep + SSCR_COIL_OFS)))
    else $error("second coil index not offset by 256");
  a_mstep_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_MSTEP)
      |=> (wb_dat_o == {22'h0, $past(st.core.mstep)}))
    else $error("microstep readback wrong");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // chopper word is back at its reset value once reset is released
  a_chop_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i)
      |-> (chop_cfg_o == SSCR_CHOP_RST))
    else $error("chopper config not at reset value after reset");

  // pwm word keeps only the implemented low bits of its reset value
  a_pwm_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i)
      |-> (pwm_cfg_o == SSCR_QUIET_PWM_CONFIGURATION_RST[SSCR_QUIET_PWM_CONFIGURATION_W-1:0]))
    else $error("pwm config not at reset value after reset");

  // status and mask are cleared, so no stale interrupt survives reset
  a_irq_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i)
      |-> !irq_o)
    else $error("interrupt line high after reset");

  // chopper readback shows the stored word
  a_chop_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_CHOP)
      |=> (wb_dat_o == $past(st.chop)))
    else $error("chopper readback wrong");

  // pwm readback is zero extended above the implemented bits
  a_pwm_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_QUIET_PWM_CONFIGURATION)
      |=> (wb_dat_o == {10'h0, $past(st.pwm)}))
    else $error("pwm config readback wrong");

  // driver status readback is the sampled core word, all 32 bits
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && idx == SSCR_IDX_DRVST)
      |=> (wb_dat_o == $past(st.core.driver_status_flags)))
    else $error("driver status readback wrong");

  // holes in the map read as zero rather than leaking a neighbour
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && take && !req.we && !is_mapped(idx))
      |=> (wb_dat_o == 32'h0))
    else $error("unmapped word did not read zero");

  // only a write to its own word may change the pwm configuration
  a_pwm_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx != SSCR_IDX_QUIET_PWM_CONFIGURATION)
      |=> $stable(pwm_cfg_o))
    else $error("pwm config changed by foreign write");

  // writes to report words leave every software-owned value alone
  a_ro_writes: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && is_readonly(idx))
      |=> ($stable(st.imsk) && $stable(chop_cfg_o) && $stable(pwm_cfg_o)))
    else $error("write to read-only word had an effect");

  // ack is exactly the taken request of the cycle before
  a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i
      |=> (wb_ack_o == $past(take)))
    else $error("ack not one cycle after request");

  // read data stays put while no request is taken
  a_rdat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !take)
      |=> $stable(wb_dat_o))
    else $error("read data moved without a request");

  // clock enable low freezes every bit of state
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i
      |=> $stable(st))
    else $error("state moved while clock enable low");

  // a regulator update always sets its sticky bit, even against a clear
  a_upd_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_upd_i)
      |=> st.ist[SSCR_IRQ_REG])
    else $error("regulator update not recorded");

  // wrap from the last table entry to the first marks one full period
  a_wrap_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st.core.mstep == 10'h3ff && mstep_i == 10'h000)
      |=> st.ist[SSCR_IRQ_WRAP])
    else $error("counter wrap not recorded");

  // any change of the driver status word is recorded
  a_drv_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st.core.driver_status_flags != driver_status_flags_i)
      |=> st.ist[SSCR_IRQ_DRV])
    else $error("driver status change not recorded");

  // a one written to a status bit clears it when no new event competes
  a_clear_ist: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx == SSCR_IDX_IRQST && wmask[SSCR_IRQ_REG] && !reg_upd_i)
      |=> !st.ist[SSCR_IRQ_REG])
    else $error("status bit not cleared by write");

  // status bits are sticky until software writes to the status word
  a_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ist[SSCR_IRQ_WRAP] && !(ce_i && wr_take && idx == SSCR_IDX_IRQST))
      |=> st.ist[SSCR_IRQ_WRAP])
    else $error("sticky status bit lost");

  // mask takes the low lane of a write to its word
  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_take && idx == SSCR_IDX_IRQMSK && req.sel[0])
      |=> (st.imsk == $past(wb_dat_i[SSCR_NIRQ-1:0])))
    else $error("interrupt mask write not stored");
endmodule
`default_nettype wire

// ===== sscr_tb.sv
// self-checking bench for the sequencer and chopper register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sscr_pkg::*;
  logic        clk_i = 1'b0;   // 100 MHz clock
  logic        rst_i = 1'b1;   // synchronous reset
  logic        ce_i  = 1'b1;   // clock enable, held high except in the freeze test
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0, rdat, rd;
  logic        ack, irq, upd = 1'b0;
  logic [9:0]  mstep = 10'h000, idx1, idx2;
  logic [31:0] drv = 32'h0, chop;
  logic [7:0]  duty = 8'h00, aofs = 8'h00, agrad = 8'h00;
  logic [8:0]  sofs = 9'h000;
  logic [21:0] pwm;
  int          fails = 0, tests_run = 0, cycles = 0;
  sscr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mstep_i(mstep), .driver_status_flags_i(drv), .duty_i(duty), .sofs_i(sofs),
    .aofs_i(aofs), .agrad_i(agrad), .reg_upd_i(upd), .chop_cfg_o(chop), .pwm_cfg_o(pwm),
    .first_idx_o(idx1), .second_idx_o(idx2), .irq_o(irq));
  // free running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far above the 130 or so cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end
  // one compare, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    // no limit here: only the bench's cycle guard ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // reset values, a byte-lane write on the chopper word and a full write on the pwm word
  task automatic t_config;
    wb(1'b0, 10'h1b0, 32'h0, 4'hf); chk(rd, 32'h13008001);
    wb(1'b0, 10'h1c0, 32'h0, 4'hf); chk(rd, 32'h000d1024);
    wb(1'b1, 10'h1b0, 32'ha5a5a5a5, 4'h5);
    wb(1'b0, 10'h1b0, 32'h0, 4'hf); chk(rd, 32'h13a580a5);
    chk(chop, 32'h13a580a5);
    wb(1'b1, 10'h1c0, 32'hffffffff, 4'hf);
    wb(1'b0, 10'h1c0, 32'h0, 4'hf); chk(rd, 32'h003fffff);
    chk({10'h0, pwm}, 32'h003fffff);
  endtask
  // read-only reports follow the core and ignore writes
  task automatic t_readonly;
    @(posedge clk_i);
    mstep <= 10'h2c5; drv <= 32'h8000_1f03; duty <= 8'hff; sofs <= 9'h101;
    aofs <= 8'h24; agrad <= 8'he7;
    repeat (3) @(posedge clk_i);
    chk({22'h0, idx1}, 32'h2c5);
    chk({22'h0, idx2}, 32'h3c5);
    wb(1'b1, 10'h1a8, 32'h0, 4'hf); wb(1'b1, 10'h1bc, 32'h0, 4'hf);
    wb(1'b1, 10'h1c4, 32'h0, 4'hf); wb(1'b1, 10'h1c8, 32'h0, 4'hf);
    wb(1'b0, 10'h1a8, 32'h0, 4'hf); chk(rd, 32'h2c5);
    wb(1'b0, 10'h1bc, 32'h0, 4'hf); chk(rd, 32'h80001f03);
    wb(1'b0, 10'h1c4, 32'h0, 4'hf); chk(rd, 32'h010100ff);
    wb(1'b0, 10'h1c8, 32'h0, 4'hf); chk(rd, 32'h00e70024);
    wb(1'b0, 10'h3fc, 32'h0, 4'hf); chk(rd, 32'h0);
    @(posedge clk_i);
    mstep <= 10'h3ff; sofs <= 9'h1ff;
    @(posedge clk_i);
    mstep <= 10'h000;
    repeat (3) @(posedge clk_i);
    chk({22'h0, idx2}, 32'h100);
    wb(1'b0, 10'h1c4, 32'h0, 4'hf); chk(rd, 32'h01ff00ff);
    wb(1'b0, 10'h1e0, 32'h0, 4'hf); chk(rd & 32'h1, 32'h1);
  endtask
  // sticky status, mask and write-one-to-clear on the interrupt line
  task automatic t_irq;
    wb(1'b1, 10'h1e0, 32'h7, 4'h1);
    wb(1'b1, 10'h1e4, 32'h4, 4'h1);
    chk(irq, 1'b0);
    @(posedge clk_i);
    upd <= 1'b1;
    @(posedge clk_i);
    upd <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b0, 10'h1e0, 32'h0, 4'hf); chk(rd, 32'h4);
    wb(1'b1, 10'h1e4, 32'h0, 4'h1);
    @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, 10'h1e4, 32'h4, 4'h1);
    wb(1'b1, 10'h1e0, 32'h4, 4'h1);
    @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b0, 10'h1e0, 32'h0, 4'hf); chk(rd, 32'h0);
    // regulator pulse in the very cycle a clear is taken: the set must win
    fork
      wb(1'b1, 10'h1e0, 32'h4, 4'h1);
      begin
        @(posedge clk_i);
        upd <= 1'b1;
        @(posedge clk_i);
        upd <= 1'b0;
      end
    join
    wb(1'b0, 10'h1e0, 32'h0, 4'hf); chk(rd, 32'h4);
    chk(irq, 1'b1);
  endtask
  // clock enable low freezes the sampled copies and the index outputs
  task automatic t_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    mstep <= 10'h155;
    repeat (4) @(posedge clk_i);
    chk({22'h0, idx1}, 32'h0);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({22'h0, idx1}, 32'h155);
    chk({22'h0, idx2}, 32'h255);
  endtask
  // reset in mid-run restores both configuration words and drops the line
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 10'h1b0, 32'h0, 4'hf); chk(rd, 32'h13008001);
    chk({10'h0, pwm}, 32'h000d1024);
    chk(irq, 1'b0);
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("mismatches %0d of %0d compares", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_config();
    t_readonly();
    t_irq();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
